// ### rtl/abt_trigger_decode.sv
// Audio bus decoder, trigger unit and frame record writer behind APB
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Four trigger types: data, window, word-select edge, error.
// - Audio trigger source forces decoding on and routes the trigger to it.
// - Data and window types evaluate only the channels chosen for comparison.
// - Operators: equal, not equal, greater, less, in range, out of range.
// - Don't-care channel never blocks nor causes a trigger.
// - Words and compare values are signed, limited to the word length.
// - Channel conditions combine within one frame only.
// - AND: every selected channel must match.
// - OR: any selected channel match triggers.
// - Window: conditions hold for a programmed count of consecutive frames.
// - Word-select trigger on chosen edge after polarity is applied.
// - Each frame records a sequence number and start time versus trigger.
// - Each frame records time since the previous frame start.
// - Each record holds every channel word, two or up to eight slots.
// - Normal polarity: low word select is left; inverted swaps.
// - Standard format: word starts one bit after the word-select change.
// - TDM frame starts at the first bit edge after the sync edge.
// - TDM slot length at least word length plus offset; the code clips the offset to fit a shorter slot.
module abt_trigger_decode
	import abt_pkg::*;
(
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RST_B,
	// APB slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// Audio bus pins
	input  wire logic        I_WS,
	input  wire logic        I_SCK,
	input  wire logic        I_SD,
	// Trigger and status
	output logic             O_TRIG,
	output logic             O_DECODE_ON
);
	logic [2:0]  sck_s_r;
	logic [1:0]  ws_s_r, sd_s_r;
	logic [31:0] ctrl_r, cfg_r, ts_r, fnum_r, fts_r, pts_r, ttrg_r, sh_r;
	logic [31:0] min_r [NCH];
	logic [31:0] max_r [NCH];
	logic [23:0] chop_r;
	logic [15:0] win_r, wcnt_r;
	logic [9:0]  gcnt_r, idx, end2;
	logic [5:0]  ic_r, wl, off, offe, chl, dly;
	logic [3:0]  sl_r, nch;
	logic [1:0]  hcnt_r;
	logic [7:0]  have_r, hit_r, exp_m, sel_m, cap_m, have_nx, hit_nx;
	logic        ws_prev_r, started_r, trgf_r, errf_r;
	logic        src_aud, dec_on, bit_ev, wsp, trans, fstart, is_tdm;
	logic        cap_a, cap_r, cap_t, cap, cap_hit, fdone, ferr, ws_ev, sat, win_hit, fire;
	logic        wr_go, rd_ok, wr_ok, clr_t, clr_e, mem_we;
	logic [2:0]  cap_ch;
	abt_op_e     cap_op;
	logic [31:0] cap_w, rd_v, mem_q, mem_d;
	logic signed [31:0] cap_sw, lo, hi;
	logic [REC_AW-1:0]  mem_a;
	abt_tt_e     ttype;
	abt_fmt_e    fmt;

	// Sign-extend the low n bits of a word
	function automatic logic signed [31:0] f_sext(input logic [31:0] v, input logic [5:0] n);
		logic [5:0] s;
		s = 6'd32 - n;
		return $signed(v << s) >>> s;
	endfunction

	// One channel condition
	function automatic logic f_match(input abt_op_e op, input logic signed [31:0] w, l, h);
		case (op)
			OP_EQ: return w == l;
			OP_NE: return w != l;
			OP_GT: return w > l;
			OP_LT: return w < l;
			OP_IN: return (w >= l) && (w <= h);
			OP_OUT: return (w < l) || (w > h);
			default: return 1'b0;
		endcase
	endfunction

	// Configuration fields
	assign src_aud = ctrl_r[C_SRC];
	assign dec_on  = ctrl_r[C_DEC] | src_aud;
	assign ttype   = abt_tt_e'(ctrl_r[C_TT+:2]);
	assign fmt     = abt_fmt_e'(ctrl_r[C_FMT+:2]);
	assign wl      = cfg_r[F_WL+:6];
	assign off     = cfg_r[F_OFF+:6];
	assign chl     = cfg_r[F_CHL+:6];
	assign nch     = cfg_r[F_NCH+:4];
	assign dly     = cfg_r[F_DLY+:6];
	assign is_tdm  = fmt == FMT_TDM;
	// Oversized offsets are clipped so a word always fits its slot
	assign offe    = (chl >= wl + off) ? off : chl - wl;

	// Pin synchronisers; only the second stage onward is looked at
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			sck_s_r <= 3'h0;
			ws_s_r  <= 2'h0;
			sd_s_r  <= 2'h0;
		end else begin
			sck_s_r <= {sck_s_r[1:0], I_SCK};
			ws_s_r  <= {ws_s_r[0], I_WS};
			sd_s_r  <= {sd_s_r[0], I_SD};
		end
	end

	// Bit edge, polarity-applied word select and frame boundaries
	assign bit_ev = dec_on && (sck_s_r[2:1] == (ctrl_r[C_FALL] ? 2'b10 : 2'b01));
	assign wsp    = ws_s_r[1] ^ ctrl_r[C_INV];
	assign trans  = bit_ev && (wsp != ws_prev_r);
	assign fstart = trans && (is_tdm ? wsp : !wsp);
	assign ws_ev  = trans && (wsp == ctrl_r[C_RISE]);

	// Word capture points for each format
	assign idx   = trans ? 10'h0 : gcnt_r;
	assign end2  = (fmt == FMT_STD ? 10'h1 : {4'h0, off}) + {4'h0, wl} - 10'h1;
	assign cap_a = bit_ev && !is_tdm && fmt != FMT_RIGHT_ALIGNED && idx == end2;
	assign cap_r = trans && fmt == FMT_RIGHT_ALIGNED;
	assign cap_t = bit_ev && is_tdm && gcnt_r >= {4'h0, dly} && ic_r == offe + wl - 6'h1 && sl_r < nch;
	assign cap    = cap_a | cap_r | cap_t;
	assign cap_ch = is_tdm ? sl_r[2:0] : {2'b00, cap_r ? ws_prev_r : wsp};
	assign cap_w  = cap_r ? sh_r : {sh_r[30:0], sd_s_r[1]};
	assign cap_sw = f_sext(cap_w, wl);
	assign cap_op = abt_op_e'(chop_r[3*cap_ch+:3]);
	assign lo     = f_sext(min_r[cap_ch], wl);
	assign hi     = f_sext(max_r[cap_ch], wl);
	assign cap_hit = f_match(cap_op, cap_sw, lo, hi);

	// Channel masks for the frame in progress
	assign exp_m   = is_tdm ? 8'(9'h0ff >> (4'd8 - nch)) : 8'h03;
	assign cap_m   = cap ? 8'(9'h001 << cap_ch) : 8'h00;
	assign have_nx = have_r | cap_m;
	assign hit_nx  = hit_r | (cap_hit ? cap_m : 8'h00);
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			sel_m[i] = exp_m[i] && chop_r[3*i+:3] < 3'h6;
		end
	end
	assign fdone = cap && have_nx == exp_m && have_r != exp_m;
	assign ferr  = fstart && started_r && have_nx != exp_m;

	// Combination of channel results
	assign sat = ctrl_r[C_OR] ? |(hit_nx & sel_m)
		: (sel_m != 8'h00 && (hit_nx & sel_m) == sel_m);
	assign win_hit = (wcnt_r + 16'h1) >= win_r;

	// Trigger type select; only fires while the audio bus is the source
	always_comb begin
		case (ttype)
			TT_DATA: fire = fdone && sat;
			TT_WINDOW: fire = fdone && sat && win_hit;
			TT_WSEL: fire = ws_ev;
			default: fire = ferr;
		endcase
		fire = fire && src_aud;
	end

	// Bit counters, shift register and word-select history
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			gcnt_r    <= 10'h0;
			ic_r      <= 6'h0;
			sl_r      <= 4'h0;
			sh_r      <= 32'h0;
			ws_prev_r <= 1'b0;
		end else if (bit_ev) begin
			sh_r      <= {sh_r[30:0], sd_s_r[1]};
			ws_prev_r <= wsp;
			if (trans) begin
				gcnt_r <= is_tdm ? 10'h0 : 10'h1;
			end else if (gcnt_r != 10'h3ff) begin
				gcnt_r <= gcnt_r + 10'h1;
			end
			if (trans && is_tdm) begin
				ic_r <= 6'h0;
				sl_r <= 4'h0;
			end else if (gcnt_r >= {4'h0, dly}) begin
				ic_r <= (ic_r == chl - 6'h1) ? 6'h0 : ic_r + 6'h1;
				if (ic_r == chl - 6'h1 && sl_r != 4'hf) begin
					sl_r <= sl_r + 4'h1;
				end
			end
		end else if (!dec_on) begin
			ws_prev_r <= wsp; // Track the idle level so the first frame edge counts
		end
	end

	// Per-frame capture and match state
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			have_r    <= 8'h0;
			hit_r     <= 8'h0;
			started_r <= 1'b0;
		end else if (fstart) begin
			have_r    <= 8'h0;
			hit_r     <= 8'h0;
			started_r <= 1'b1;
		end else begin
			have_r <= have_nx;
			hit_r  <= hit_nx;
		end
	end

	// Consecutive satisfied frames for the window type
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			wcnt_r <= 16'h0;
		end else if (ferr || (fdone && (!sat || win_hit))) begin
			wcnt_r <= 16'h0;
		end else if (fdone) begin
			wcnt_r <= wcnt_r + 16'h1;
		end
	end

	// Trigger output, sticky flags (set beats clear) and trigger time
	assign clr_t = wr_go && I_PADDR == A_STAT && I_PWDATA[S_TRG];
	assign clr_e = wr_go && I_PADDR == A_STAT && I_PWDATA[S_ERR];
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_TRIG      <= 1'b0;
			O_DECODE_ON <= 1'b0;
			trgf_r      <= 1'b0;
			errf_r      <= 1'b0;
			ttrg_r      <= 32'h0;
		end else begin
			O_TRIG      <= fire;
			O_DECODE_ON <= dec_on;
			trgf_r      <= fire | (trgf_r & !clr_t);
			errf_r      <= (ferr && dec_on) | (errf_r & !clr_e);
			if (fire && !trgf_r) begin
				ttrg_r <= ts_r;
			end
		end
	end

	// Timestamp, frame numbering and header write sequencing
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			ts_r   <= 32'h0;
			fnum_r <= 32'h0;
			fts_r  <= 32'h0;
			pts_r  <= 32'h0;
			hcnt_r <= 2'h0;
		end else begin
			ts_r <= ts_r + 32'h1;
			if (fstart) begin
				fnum_r <= fnum_r + 32'h1;
				pts_r  <= fts_r;
				fts_r  <= ts_r;
				hcnt_r <= 2'h1;
			end else if (hcnt_r != 2'h0) begin
				hcnt_r <= hcnt_r + 2'h1;
			end
		end
	end

	// Record writes; a word capture wins over a header word, which the
	// slow bit clock keeps from ever colliding
	always_comb begin
		mem_we = cap || hcnt_r != 2'h0;
		mem_d  = cap_sw;
		mem_a  = {fnum_r[3:0], RF_WORD + {1'b0, cap_ch}};
		if (!cap) begin
			mem_a = {fnum_r[3:0], 2'b00, hcnt_r - 2'h1};
			if (hcnt_r == 2'h1) begin
				mem_d = fnum_r;
			end else if (hcnt_r == 2'h2) begin
				mem_d = fts_r;
			end else begin
				mem_d = fts_r - pts_r;
			end
		end
	end

	abt_rec_mem u_mem (
		.i_clk   (I_CLK),
		.i_we    (mem_we),
		.i_waddr (mem_a),
		.i_wdata (mem_d),
		.i_raddr (I_PADDR[REC_AW+1:2]),
		.o_rdata (mem_q)
	);

	// APB read mux and address decode
	always_comb begin
		rd_v  = 32'h0;
		rd_ok = 1'b1;
		wr_ok = 1'b1;
		if (I_PADDR == A_CTRL) begin
			rd_v = ctrl_r;
		end else if (I_PADDR == A_CFG) begin
			rd_v = cfg_r;
		end else if (I_PADDR == A_WIN) begin
			rd_v = {16'h0, win_r};
		end else if (I_PADDR == A_CHOP) begin
			rd_v = {8'h0, chop_r};
		end else if (I_PADDR == A_STAT) begin
			rd_v = {29'h0, O_DECODE_ON, errf_r, trgf_r};
		end else if (I_PADDR == A_FNUM) begin
			rd_v  = fnum_r;
			wr_ok = 1'b0;
		end else if (I_PADDR == A_TTS) begin
			rd_v  = ttrg_r;
			wr_ok = 1'b0;
		end else if (I_PADDR[11:5] == A_MIN[11:5]) begin
			rd_v = min_r[I_PADDR[4:2]];
		end else if (I_PADDR[11:5] == A_MAX[11:5]) begin
			rd_v = max_r[I_PADDR[4:2]];
		end else if (I_PADDR[11:10] == A_REC[11:10]) begin
			// Start times are shown relative to the trigger point
			rd_v  = (I_PADDR[5:2] == RF_START) ? mem_q - ttrg_r : mem_q;
			wr_ok = 1'b0;
		end else begin
			rd_ok = 1'b0;
			wr_ok = 1'b0;
		end
	end

	// APB answer: one wait state, so record reads see registered memory data
	assign wr_go = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && wr_ok;
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_PREADY  <= 1'b0;
			O_PRDATA  <= 32'h0;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
			if (I_PSEL && I_PENABLE && !O_PREADY) begin
				O_PRDATA  <= I_PWRITE ? 32'h0 : rd_v;
				O_PSLVERR <= I_PWRITE ? !wr_ok : !rd_ok;
			end
		end
	end

	// Software-written configuration
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			ctrl_r <= CTRL_RST;
			cfg_r  <= CFG_RST;
			win_r  <= WIN_RST;
			chop_r <= CHOP_RST;
			for (int i = 0; i < NCH; i++) begin
				min_r[i] <= 32'h0;
				max_r[i] <= 32'h0;
			end
		end else if (wr_go) begin
			if (I_PADDR == A_CTRL) begin
				ctrl_r <= I_PWDATA;
			end else if (I_PADDR == A_CFG) begin
				cfg_r <= I_PWDATA;
			end else if (I_PADDR == A_WIN) begin
				win_r <= I_PWDATA[15:0];
			end else if (I_PADDR == A_CHOP) begin
				chop_r <= I_PWDATA[23:0];
			end else if (I_PADDR[11:5] == A_MIN[11:5]) begin
				min_r[I_PADDR[4:2]] <= I_PWDATA;
			end else if (I_PADDR[11:5] == A_MAX[11:5]) begin
				max_r[I_PADDR[4:2]] <= I_PWDATA;
			end
		end
	end

	// Checks
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);

	trig_cause_a: assert property (O_TRIG |-> $past(fire) && $past(src_aud))
		else $error("trigger without audio source cause");
	dec_force_a: assert property (src_aud |=> O_DECODE_ON)
		else $error("decode not forced on");
	type_sel_a: assert property (fire |-> (ttype == TT_WSEL) ? ws_ev
		: (ttype == TT_ERROR) ? ferr : fdone)
		else $error("trigger from wrong type");
	chan_sel_a: assert property (fdone && (hit_nx & sel_m) == 8'h0 && ttype == TT_DATA |=> !O_TRIG)
		else $error("unselected channel caused trigger");
	and_comb_a: assert property (fdone && !ctrl_r[C_OR] && (sel_m & ~hit_nx) != 8'h0 |=> !O_TRIG)
		else $error("AND fired with a failing channel");
	or_comb_a: assert property (fdone && ctrl_r[C_OR] && src_aud && ttype == TT_DATA
		&& (sel_m & hit_nx) != 8'h0 |=> O_TRIG)
		else $error("OR missed a matching channel");
	win_cnt_a: assert property (fdone && !sat |=> wcnt_r == 16'h0 && !O_TRIG)
		else $error("window count not restarted");
	ws_edge_a: assert property (ws_ev && ttype == TT_WSEL && src_aud |=> O_TRIG ##1 !O_TRIG)
		else $error("word select edge missed");
	err_trig_a: assert property (ferr && ttype == TT_ERROR && src_aud |=> O_TRIG && errf_r)
		else $error("framing error not triggered");
	fnum_a: assert property (fstart |=> fnum_r == $past(fnum_r) + 32'h1 ##2 hcnt_r == 2'h3)
		else $error("frame number or header sequence wrong");
	range_a: assert property (cap && cap_op == OP_IN && cap_sw == hi && lo <= hi |-> cap_hit)
		else $error("range upper bound not inclusive");

	data_trig_c: cover property (fdone && ttype == TT_DATA && fire);
	win_trig_c: cover property (fdone && ttype == TT_WINDOW && fire);
	ws_trig_c: cover property (ws_ev && ttype == TT_WSEL && fire);
	err_trig_c: cover property (ferr && ttype == TT_ERROR && fire);
endmodule
`default_nettype wire

// ### rtl/abt_pkg.sv
// Constants and types shared by the audio trigger and decode block
package abt_pkg;
	// Register byte offsets
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_CFG  = 12'h004;
	localparam logic [11:0] A_WIN  = 12'h008;
	localparam logic [11:0] A_CHOP = 12'h00c;
	localparam logic [11:0] A_STAT = 12'h010;
	localparam logic [11:0] A_FNUM = 12'h014;
	localparam logic [11:0] A_TTS  = 12'h018;
	localparam logic [11:0] A_MIN  = 12'h040; // Eight words, one per channel
	localparam logic [11:0] A_MAX  = 12'h060;
	localparam logic [11:0] A_REC  = 12'h400; // 16 records of 16 words
	// Control field positions
	localparam int C_DEC  = 0;
	localparam int C_SRC  = 1;
	localparam int C_TT   = 2;
	localparam int C_OR   = 4;
	localparam int C_RISE = 5;
	localparam int C_INV  = 6;
	localparam int C_FALL = 7;
	localparam int C_FMT  = 8;
	// Configuration field positions
	localparam int F_WL  = 0;
	localparam int F_OFF = 6;
	localparam int F_CHL = 12;
	localparam int F_NCH = 18;
	localparam int F_DLY = 22;
	// Status bit positions
	localparam int S_TRG = 0;
	localparam int S_ERR = 1;
	localparam int S_DEC = 2;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CFG_RST  = 32'h000a_0010;
	localparam logic [15:0] WIN_RST  = 16'h0001;
	localparam logic [23:0] CHOP_RST = 24'hdb6db6;
	// Record layout and size
	localparam logic [3:0] RF_NUM   = 4'h0;
	localparam logic [3:0] RF_START = 4'h1;
	localparam logic [3:0] RF_DIFF  = 4'h2;
	localparam logic [3:0] RF_WORD  = 4'h3;
	localparam int REC_AW = 8;
	localparam int NCH    = 8;
	// Modes
	typedef enum logic [1:0] {FMT_STD, FMT_LEFT_ALIGNED, FMT_RIGHT_ALIGNED, FMT_TDM} abt_fmt_e;
	typedef enum logic [1:0] {TT_DATA, TT_WINDOW, TT_WSEL, TT_ERROR} abt_tt_e;
	typedef enum logic [2:0] {OP_EQ, OP_NE, OP_GT, OP_LT, OP_IN, OP_OUT, OP_DC} abt_op_e;
endpackage

// ### rtl/abt_rec_mem.sv
// Frame record memory with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
module abt_rec_mem
	import abt_pkg::*;
(
	// Clock
	input  wire logic              i_clk,
	// Write port
	input  wire logic              i_we,
	input  wire logic [REC_AW-1:0] i_waddr,
	input  wire logic [31:0]       i_wdata,
	// Read port
	input  wire logic [REC_AW-1:0] i_raddr,
	output logic      [31:0]       o_rdata
);
	logic [31:0] mem [2**REC_AW];

	// No reset on the array; records are valid once written
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule
`default_nettype wire

// ### sim/abt_audio_tx.sv
// Behavioural audio transmitter for the standard two-channel format
`timescale 1ns/100ps
`default_nettype none
module abt_audio_tx (
	// Link pins
	output var logic o_ws,
	output var logic o_sck,
	output var logic o_sd
);
	logic inv = 1'b0;

	// Idle: bit clock still, word select on the right channel
	initial begin
		o_ws = 1'b1;
		o_sck = 1'b0;
		o_sd = 1'b0;
	end

	// Polarity change parks word select on the right-channel level
	task automatic set_inv(input logic v);
		#0.3;
		inv = v;
		o_ws = ~v;
	endtask

	// One channel: slot 0 carries the inverted previous data bit, then the word MSB first
	task automatic half(input logic right, input logic [31:0] v, input int wl, input int n);
		o_ws = right ^ inv;
		for (int i = 0; i <= n; i++) begin
			o_sd = (i == 0) ? ~o_sd : v[wl-i];
			#62.5 o_sck = 1'b1;
			#62.5 o_sck = 1'b0;
		end
	endtask

	// Left then right; a short right half makes a broken frame
	task automatic frame(input logic [31:0] l, input logic [31:0] r, input int wl, input int nr);
		// Small offset keeps pin changes off the sampling clock edges
		#0.3;
		half(1'b0, l, wl, wl);
		half(1'b1, r, wl, nr);
		o_sd = ~o_sd; // Released line must not look like valid data
	endtask
endmodule
`default_nettype wire

// ### sim/audio_bus_trigger_decode_bench.sv
// Self-checking bench for the audio trigger and decode block
`timescale 1ns/100ps
`default_nettype none
module audio_bus_trigger_decode_bench;
	import abt_pkg::*;
	// Operator table: code, min, max, left word, trigger expected
	localparam logic [2:0]  OPS [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
	localparam logic [31:0] MNS [6] = '{32'hffff_fffb, 32'hffff_fffb, 32'h0, 32'h0, 32'hffff_fffe, 32'hffff_fffe};
	localparam logic [31:0] MXS [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3, 32'h3};
	localparam logic [31:0] VLS [6] = '{32'hfb, 32'hfb, 32'h80, 32'h80, 32'h03, 32'hfe};
	localparam int          EXS [6] = '{1, 0, 0, 1, 1, 0};
	// Design pins
	logic        I_CLK     = 1'b0;
	logic        I_RST_B   = 1'b0;
	logic        I_PSEL    = 1'b0;
	logic        I_PENABLE = 1'b0;
	logic        I_PWRITE  = 1'b0;
	logic [11:0] I_PADDR   = 12'h000;
	logic [31:0] I_PWDATA  = 32'h0;
	logic [31:0] O_PRDATA;
	logic        O_PREADY;
	logic        O_PSLVERR;
	logic        O_TRIG;
	logic        O_DECODE_ON;
	wire         I_WS;
	wire         I_SCK;
	wire         I_SD;
	// Bench state
	logic [31:0] rdat;
	logic        rerr;
	logic [11:0] base;
	int          n_errors  = 0;
	int          cmp_count = 0;
	int          n_trig    = 0;
	int          nf        = 0;
	int          cyc       = 0;

	always #2 I_CLK = ~I_CLK;

	abt_trigger_decode abt_trigger_decode_inst (
		.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
		.I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
		.O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_WS(I_WS), .I_SCK(I_SCK), .I_SD(I_SD),
		.O_TRIG(O_TRIG), .O_DECODE_ON(O_DECODE_ON));
	abt_audio_tx abt_audio_tx_inst (.o_ws(I_WS), .o_sck(I_SCK), .o_sd(I_SD));

	// Trigger pulses counted as they stand, one cycle each
	always @(posedge I_CLK) begin
		if (O_TRIG === 1'b1) begin
			n_trig++;
		end
	end

	// Hang guard, well above the expected run of some 20000 cycles
	always @(posedge I_CLK) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			end_sim();
		end
	end

	task automatic end_sim;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge I_CLK);
		I_PSEL <= 1'b1;
		I_PENABLE <= 1'b0;
		I_PWRITE <= w;
		I_PADDR <= a;
		I_PWDATA <= d;
		@(posedge I_CLK);
		I_PENABLE <= 1'b1;
		@(posedge I_CLK);
		while (O_PREADY !== 1'b1) begin
			@(posedge I_CLK);
		end
		rdat = O_PRDATA;
		rerr = O_PSLVERR;
		I_PSEL <= 1'b0;
		I_PENABLE <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask

	// Frame of 8-bit words, then time for the decision to land
	task automatic fr(input logic [31:0] l, input logic [31:0] r, input int nr);
		abt_audio_tx_inst.frame(l, r, 8, nr);
		nf++;
		repeat (20) @(posedge I_CLK);
	endtask

	task automatic trig(input logic [31:0] l, input logic [31:0] r, input int nr, input int e);
		int t0;
		t0 = n_trig;
		fr(l, r, nr);
		chk(32'(n_trig - t0), 32'(e));
	endtask

	initial begin
		repeat (6) @(posedge I_CLK);
		I_RST_B <= 1'b1;
		// Reset values and refused accesses
		rd(A_CTRL, CTRL_RST);
		rd(A_CFG, CFG_RST);
		rd(A_WIN, {16'h0, WIN_RST});
		rd(A_CHOP, {8'h0, CHOP_RST});
		chk({31'h0, O_DECODE_ON}, 32'h0);
		acc(1'b0, 12'h020, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		acc(1'b1, A_FNUM, 32'h5);
		chk({31'h0, rerr}, 32'h1);
		// Audio source alone turns decoding on
		wr(A_CTRL, 32'h2);
		rd(A_STAT, 32'h4);
		chk({31'h0, O_DECODE_ON}, 32'h1);
		wr(A_CFG, 32'h000a_0008);
		wr(A_CTRL, 32'h3);
		// Every operator, signed values and inclusive bounds
		for (int i = 0; i < 6; i++) begin
			wr(A_CHOP, {8'h0, 24'hdb6db0 | {21'h0, OPS[i]}});
			wr(A_MIN, MNS[i]);
			wr(A_MAX, MXS[i]);
			trig(VLS[i], 32'h0, 8, EXS[i]);
		end
		// Record of the last frame; its start is some 594 cycles after the one before
		rd(A_FNUM, 32'(nf));
		base = A_REC + 12'((nf % 16) * 64);
		rd(base, 32'(nf));
		acc(1'b0, base + 12'h8, 32'h0);
		chk({31'h0, rdat >= 32'h24e && rdat <= 32'h256}, 32'h1);
		rd(base + 12'hc, 32'hffff_fffe);
		rd(base + 12'h10, 32'h0);
		// Left aligned with a one-bit offset
		wr(A_CFG, 32'h000a_0048);
		wr(A_CTRL, 32'h103);
		trig(32'h7, 32'h0, 8, 1);
		trig(32'h2, 32'h0, 8, 0);
		// Right aligned: a frame is decided when the next one starts
		wr(A_CFG, 32'h000a_0008);
		wr(A_CTRL, 32'h203);
		trig(32'h7, 32'h0, 8, 0);
		trig(32'h2, 32'h0, 8, 1);
		// All channels ignored: never fires
		wr(A_CTRL, 32'h13);
		wr(A_CHOP, {8'h0, CHOP_RST});
		trig(32'hfb, 32'h0, 8, 0);
		// Two channels combined within one frame
		wr(A_CHOP, 32'h00db_6d80);
		wr(A_MIN, 32'h1);
		wr(A_MIN + 12'h4, 32'h2);
		wr(A_CTRL, 32'h3);
		trig(32'h1, 32'h3, 8, 0);
		trig(32'h1, 32'h2, 8, 1);
		fr(32'h1, 32'h0, 8);
		trig(32'h0, 32'h2, 8, 0);
		wr(A_CTRL, 32'h13);
		trig(32'h1, 32'h3, 8, 1);
		trig(32'h0, 32'h0, 8, 0);
		// Window of three consecutive matching frames
		wr(A_CHOP, 32'h00db_6db0);
		wr(A_WIN, 32'h3);
		wr(A_CTRL, 32'h7);
		trig(32'h1, 32'h0, 8, 0);
		trig(32'h1, 32'h0, 8, 0);
		trig(32'h0, 32'h0, 8, 0);
		trig(32'h1, 32'h0, 8, 0);
		trig(32'h1, 32'h0, 8, 0);
		trig(32'h1, 32'h0, 8, 1);
		trig(32'h1, 32'h0, 8, 0);
		// Word-select edges, rising then falling
		wr(A_CTRL, 32'h2b);
		trig(32'h0, 32'h0, 8, 1);
		wr(A_CTRL, 32'h0b);
		trig(32'h0, 32'h0, 8, 1);
		// Inverted polarity: high word select is the left channel
		wr(A_CTRL, 32'h43);
		abt_audio_tx_inst.set_inv(1'b1);
		fr(32'h0, 32'h0, 8);
		trig(32'h1, 32'h0, 8, 1);
		trig(32'h0, 32'h1, 8, 0);
		abt_audio_tx_inst.set_inv(1'b0);
		wr(A_CTRL, 32'h3);
		fr(32'h0, 32'h0, 8);
		// Frame cut short, noticed when the next one starts
		wr(A_STAT, 32'h3);
		wr(A_CTRL, 32'hf);
		trig(32'h5, 32'h5, 3, 0);
		trig(32'h5, 32'h5, 8, 1);
		rd(A_STAT, 32'h7);
		wr(A_STAT, 32'h3);
		rd(A_STAT, 32'h4);
		end_sim();
	end
endmodule
`default_nettype wire
